// File: rtl/gmb_pkg.sv
// shared constants, types and crc helper for the gripper register bank
package gmb_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int BAUD = 115200;
  localparam int BAUD_DIV = CLK_HZ / BAUD;
  // inter-frame silence, fixed figure for rates above 19200 baud
  localparam int GAP_US = 1750;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;

  localparam logic [7:0] SRV_ADDR = 8'h56;
  localparam logic [7:0] FC_READ_IN = 8'h04;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] RD_BYTES = 8'h02;

  localparam logic [15:0] REG_STATE = 16'h03E8;
  localparam logic [15:0] REG_CURR = 16'h03EB;
  localparam logic [15:0] REG_TEMP = 16'h03EC;
  localparam logic [15:0] REG_CFG = 16'h07D0;
  localparam logic [15:0] REG_CLOSE = 16'h07D4;
  localparam logic [15:0] REG_OPEN = 16'h07D5;
  localparam logic [15:0] CFG_RESET = 16'h0007;
  localparam logic [15:0] RD_QTY = 16'h0001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  localparam logic [3:0] FRAME_LEN = 4'h8;
  localparam logic [3:0] RD_LEN = 4'h5;
  localparam logic [3:0] WR_LEN = 4'h6;

  typedef struct packed {
    logic [7:0] fault_code;
    logic motion_flag;
    logic grip_in_flag;
    logic [1:0] obj_state;
    logic [1:0] op_mode;
    logic goto_request_flag;
    logic enabled_flag;
  } gmb_status_t;

  typedef struct packed {
    logic we;
    logic sel;
    logic [15:0] data;
  } gmb_nv_wr_t;

  function automatic logic [15:0] gmb_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// File: rtl/gmb_uart.sv
// byte serialiser and deserialiser, 8 data bits, no parity, 1 stop bit
`timescale 1ns/10ps
module gmb_uart import gmb_pkg::*; #(
  parameter int DIV = BAUD_DIV
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rxd,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic txd,
  output logic rx_valid,
  output logic [7:0] rx_data
);

  logic rxd_s1_ff, rxd_s2_ff;
  logic rx_busy_ff, nxt_rx_busy;
  logic [15:0] rx_cnt_ff, nxt_rx_cnt;
  logic [3:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic rx_valid_ff, nxt_rx_valid;
  logic [15:0] tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] tx_bit_ff, nxt_tx_bit;
  logic [9:0] tx_sh_ff, nxt_tx_sh;

  ////////////////////////////////////////////////////////////////////////////
  // receive: start sampled mid-bit, then one sample per bit time
  always_comb begin
    nxt_rx_busy = rx_busy_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_valid = 1'b0;
    if (!rx_busy_ff) begin
      if (!rxd_s2_ff) begin
        nxt_rx_busy = 1'b1;
        nxt_rx_cnt = 16'(DIV / 2);
        nxt_rx_bit = 4'h0;
      end
    end else if (rx_cnt_ff != 16'h0000) begin
      nxt_rx_cnt = rx_cnt_ff - 16'h0001;
    end else begin
      nxt_rx_cnt = 16'(DIV - 1);
      nxt_rx_bit = rx_bit_ff + 4'h1;
      // glitch on idle line is not a start bit
      if (rx_bit_ff == 4'h0 && rxd_s2_ff) begin
        nxt_rx_busy = 1'b0;
      end else if (rx_bit_ff == 4'h9) begin
        nxt_rx_busy = 1'b0;
        nxt_rx_valid = rxd_s2_ff;
      end else if (rx_bit_ff != 4'h0) begin
        nxt_rx_sh = {rxd_s2_ff, rx_sh_ff[7:1]};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
      rx_busy_ff <= 1'b0;
      rx_cnt_ff <= 16'h0000;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
    end else begin
      rxd_s1_ff <= rxd;
      rxd_s2_ff <= rxd_s1_ff;
      rx_busy_ff <= nxt_rx_busy;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_valid_ff <= nxt_rx_valid;
    end
  end

  assign rx_valid = rx_valid_ff;
  assign rx_data = rx_sh_ff;

  ////////////////////////////////////////////////////////////////////////////
  // transmit: idle shifter holds ones so the line rests high
  assign tx_ready = (tx_bit_ff == 4'h0);
  assign txd = tx_sh_ff[0];

  always_comb begin
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    if (tx_ready) begin
      if (tx_valid) begin
        nxt_tx_sh = {1'b1, tx_data, 1'b0};
        nxt_tx_bit = 4'hA;
        nxt_tx_cnt = 16'(DIV - 1);
      end
    end else if (tx_cnt_ff != 16'h0000) begin
      nxt_tx_cnt = tx_cnt_ff - 16'h0001;
    end else begin
      nxt_tx_sh = {1'b1, tx_sh_ff[9:1]};
      nxt_tx_bit = tx_bit_ff - 4'h1;
      nxt_tx_cnt = 16'(DIV - 1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_cnt_ff <= 16'h0000;
      tx_bit_ff <= 4'h0;
      tx_sh_ff <= 10'h3FF;
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
    end
  end

  a_tx_idle_high: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ12
    tx_ready |-> txd) else $error("line not high while transmitter idle");
  a_tx_start_bit: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ12
    tx_ready && tx_valid |=> !txd [*8]) else $error("start bit not held");

endmodule

// File: rtl/gmb_regbank.sv
// modbus rtu server with status, current, temperature and preset registers
// How it works
// RQ1: register 03E8h reads fault code, motion, object, detection, mode, goto, enabled bits.
// RQ2: a function 04 read of one register answers address, 04, count 2, data msb first, crc.
// RQ3: register 03EBh reads the motor current in tenths of an ampere.
// RQ4: register 03ECh reads sensor A in the upper byte and sensor B in the lower byte.
// RQ5: register 07D4h takes the close preset, twice the distance in millimetres.
// RQ6: register 07D5h takes the open preset, twice the distance in millimetres.
// RQ7: the client doubles a preset and the device halves it back to millimetres.
// RQ8: each preset write goes to non-volatile storage and is reloaded after power-up.
// RQ9: a good function 06 write is answered with an exact copy of the request.
// RQ10: the client selects serial-command mode with 0003h in 07D0h before writing presets.
// RQ11: writing 0007h to 07D0h returns the device to discrete-input mode with the presets.
// RQ12: the link is 115200 baud 8N1, server address 86, functions 04, 06 and 16; the code answers only 04 and 06.
// RQ13: the configuration register starts at 0007h after power-up.
// RQ14: frames with a bad crc or another server address are dropped without reply.
`timescale 1ns/10ps
module gmb_regbank import gmb_pkg::*; #(
  parameter int GAP = GAP_CYC,
  parameter int DIV = BAUD_DIV
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic RXD,
  output logic TXD,
  output logic TX_EN,
  input wire gmb_status_t STATUS,
  input wire logic [15:0] CURRENT_TENTHS,
  input wire logic [7:0] TEMP_A,
  input wire logic [7:0] TEMP_B,
  input wire logic [15:0] NV_CLOSE_IN,
  input wire logic [15:0] NV_OPEN_IN,
  output gmb_nv_wr_t NV_WR,
  output logic [15:0] CFG_WORD,
  output logic [14:0] CLOSE_MM,
  output logic [14:0] OPEN_MM
);

  typedef enum logic [1:0] {ST_RECV, ST_EVAL, ST_SEND} gmb_state_t;

  gmb_state_t state_ff, nxt_state;
  logic [3:0] idx_ff, nxt_idx;
  logic [3:0] len_ff, nxt_len;
  logic [15:0] crc_ff, nxt_crc;
  logic [31:0] gap_ff, nxt_gap;
  logic [7:0] buf_ff [8];
  logic [7:0] nxt_buf [8];
  logic rx_valid, tx_ready, tx_valid;
  logic [7:0] rx_data, tx_byte;
  logic [15:0] reg_addr, wdata, rd_val;
  logic rd_hit, wr_hit, wr_go;
  logic [15:0] cfg_ff, nxt_cfg, close_ff, nxt_close, open_ff, nxt_open;
  logic loaded_ff, nxt_loaded;
  gmb_nv_wr_t nv_ff, nxt_nv;

  gmb_uart #(.DIV(DIV)) u_uart (
    .clk_sys(CLK_SYS),
    .resetn(RESETN),
    .rxd(RXD),
    .tx_valid(tx_valid),
    .tx_data(tx_byte),
    .tx_ready(tx_ready),
    .txd(TXD),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  assign reg_addr = {buf_ff[2], buf_ff[3]};
  assign wdata = {buf_ff[4], buf_ff[5]};
  assign wr_hit = (reg_addr == REG_CFG) || (reg_addr == REG_CLOSE) || (reg_addr == REG_OPEN);

  always_comb begin
    rd_hit = 1'b1;
    case (reg_addr)
      REG_STATE: rd_val = STATUS; // RQ1
      REG_CURR: rd_val = CURRENT_TENTHS; // RQ3
      REG_TEMP: rd_val = {TEMP_A, TEMP_B}; // RQ4
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // crc bytes go out low byte first
  assign tx_byte = (idx_ff < len_ff) ? buf_ff[idx_ff[2:0]] :
                   (idx_ff == len_ff) ? crc_ff[7:0] : crc_ff[15:8];
  // driver stays on until the stop bit of the last byte has left
  assign TX_EN = (state_ff == ST_SEND) || !tx_ready;

  ////////////////////////////////////////////////////////////////////////////
  // frame engine
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_len = len_ff;
    nxt_crc = crc_ff;
    nxt_gap = gap_ff;
    nxt_buf = buf_ff;
    tx_valid = 1'b0;
    wr_go = 1'b0;
    unique case (state_ff)
      ST_RECV: begin
        if (idx_ff == FRAME_LEN) begin
          nxt_state = ST_EVAL;
        end else if (rx_valid) begin
          nxt_buf[idx_ff[2:0]] = rx_data;
          nxt_crc = gmb_crc_byte(crc_ff, rx_data);
          nxt_idx = idx_ff + 4'h1;
          nxt_gap = 32'h0;
        end else if (idx_ff != 4'h0) begin
          nxt_gap = gap_ff + 32'h1;
          // silence ends a short frame, which is thrown away
          if (gap_ff >= 32'(GAP - 1)) begin
            nxt_idx = 4'h0;
            nxt_crc = CRC_INIT;
            nxt_gap = 32'h0;
          end
        end
      end
      ST_EVAL: begin
        nxt_state = ST_RECV;
        nxt_idx = 4'h0;
        nxt_crc = CRC_INIT;
        nxt_gap = 32'h0;
        // residue of zero over data plus crc means the frame is intact
        if (crc_ff == 16'h0000 && buf_ff[0] == SRV_ADDR) begin // RQ14
          if (buf_ff[1] == FC_READ_IN && wdata == RD_QTY && rd_hit) begin
            nxt_buf[2] = RD_BYTES; // RQ2
            nxt_buf[3] = rd_val[15:8]; // RQ2
            nxt_buf[4] = rd_val[7:0];
            nxt_len = RD_LEN;
            nxt_state = ST_SEND;
          end else if (buf_ff[1] == FC_WRITE_ONE && wr_hit) begin
            wr_go = 1'b1;
            nxt_len = WR_LEN; // RQ9
            nxt_state = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        tx_valid = 1'b1;
        if (tx_ready) begin
          if (idx_ff < len_ff) begin
            nxt_crc = gmb_crc_byte(crc_ff, buf_ff[idx_ff[2:0]]);
          end
          nxt_idx = idx_ff + 4'h1;
          if (idx_ff == len_ff + 4'h1) begin
            nxt_state = ST_RECV;
            nxt_idx = 4'h0;
            nxt_crc = CRC_INIT;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= ST_RECV;
      idx_ff <= 4'h0;
      len_ff <= 4'h0;
      crc_ff <= CRC_INIT;
      gap_ff <= 32'h0;
      for (int i = 0; i < 8; i++) begin
        buf_ff[i] <= 8'h00;
      end
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      len_ff <= nxt_len;
      crc_ff <= nxt_crc;
      gap_ff <= nxt_gap;
      buf_ff <= nxt_buf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and presets
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_close = close_ff;
    nxt_open = open_ff;
    nxt_loaded = 1'b1;
    nxt_nv = '0;
    // presets from storage, taken on the first edge after reset release
    if (!loaded_ff) begin
      nxt_close = NV_CLOSE_IN; // RQ8
      nxt_open = NV_OPEN_IN; // RQ8
    end
    if (wr_go) begin
      if (reg_addr == REG_CFG) begin
        nxt_cfg = wdata; // RQ11
      end else if (reg_addr == REG_CLOSE) begin
        nxt_close = wdata; // RQ5
        nxt_nv = '{we: 1'b1, sel: 1'b0, data: wdata}; // RQ8
      end else begin
        nxt_open = wdata; // RQ6
        nxt_nv = '{we: 1'b1, sel: 1'b1, data: wdata}; // RQ8
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cfg_ff <= CFG_RESET; // RQ13
      close_ff <= 16'h0000;
      open_ff <= 16'h0000;
      loaded_ff <= 1'b0;
      nv_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
      close_ff <= nxt_close;
      open_ff <= nxt_open;
      loaded_ff <= nxt_loaded;
      nv_ff <= nxt_nv;
    end
  end

  assign CFG_WORD = cfg_ff;
  assign NV_WR = nv_ff;
  // odd half-millimetre is truncated toward zero
  assign CLOSE_MM = close_ff[15:1]; // RQ7
  assign OPEN_MM = open_ff[15:1]; // RQ7

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  a_crc_drop: assert property ( // RQ14
    state_ff == ST_EVAL && crc_ff != 16'h0000 |=> state_ff == ST_RECV && !NV_WR.we [*2])
    else $error("bad crc frame not dropped");
  a_addr_drop: assert property ( // RQ14
    state_ff == ST_EVAL && buf_ff[0] != SRV_ADDR |=> state_ff == ST_RECV && !NV_WR.we)
    else $error("foreign address frame not dropped");
  a_read_reply: assert property ( // RQ2
    state_ff == ST_EVAL && nxt_state == ST_SEND && buf_ff[1] == FC_READ_IN
    |=> buf_ff[2] == RD_BYTES && len_ff == RD_LEN && buf_ff[1] == FC_READ_IN)
    else $error("read reply header wrong");
  a_status_word: assert property ( // RQ1
    state_ff == ST_EVAL && nxt_state == ST_SEND && buf_ff[1] == FC_READ_IN
    && reg_addr == REG_STATE |=> {buf_ff[3], buf_ff[4]} == $past(STATUS))
    else $error("status word mismatch");
  a_current_word: assert property ( // RQ3
    state_ff == ST_EVAL && nxt_state == ST_SEND && buf_ff[1] == FC_READ_IN
    && reg_addr == REG_CURR |=> {buf_ff[3], buf_ff[4]} == $past(CURRENT_TENTHS))
    else $error("current word mismatch");
  a_temp_word: assert property ( // RQ4
    state_ff == ST_EVAL && nxt_state == ST_SEND && buf_ff[1] == FC_READ_IN
    && reg_addr == REG_TEMP |=> buf_ff[3] == $past(TEMP_A) && buf_ff[4] == $past(TEMP_B))
    else $error("temperature word mismatch");
  a_close_store: assert property ( // RQ5 RQ7 RQ8
    wr_go && reg_addr == REG_CLOSE
    |=> CLOSE_MM == $past(wdata[15:1]) && NV_WR.we && !NV_WR.sel && NV_WR.data == close_ff)
    else $error("close preset not stored");
  a_open_store: assert property ( // RQ6 RQ8
    wr_go && reg_addr == REG_OPEN |=> open_ff == $past(wdata) && NV_WR.we && NV_WR.sel)
    else $error("open preset not stored");
  a_cfg_write: assert property ( // RQ11
    wr_go && reg_addr == REG_CFG |=> CFG_WORD == $past(wdata) && !NV_WR.we)
    else $error("configuration not written");
  a_echo_len: assert property ( // RQ9
    wr_go |=> state_ff == ST_SEND && len_ff == WR_LEN && idx_ff == 4'h0)
    else $error("write echo not started");

  c_read_done: cover property (state_ff == ST_SEND && nxt_state == ST_RECV && len_ff == RD_LEN);
  c_write_done: cover property (state_ff == ST_SEND && nxt_state == ST_RECV && len_ff == WR_LEN);
  c_bad_crc: cover property (state_ff == ST_EVAL && crc_ff != 16'h0000);
  c_gap_flush: cover property (state_ff == ST_RECV && idx_ff != 4'h0 ##1 idx_ff == 4'h0);

endmodule

// File: test/gmb_client_model.sv
// modbus rtu client model: sends request frames, collects replies
`timescale 1ns/10ps
module gmb_client_model import gmb_pkg::*; #(
  parameter int DIV = BAUD_DIV
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] frm [8];
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc16(input logic [7:0] f [8], input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int k = 0; k < n; k++) begin
      c ^= {8'h00, f[k]};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction
  // start, 8 data bits lsb first, 1 stop, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      repeat (DIV) @(negedge clk);
    end
  endtask
  // flip is xored into the crc to force a corrupt frame
  task automatic send_req(input logic [7:0] adr, input logic [7:0] fc,
      input logic [15:0] rg, input logic [15:0] dat, input logic [15:0] flip);
    logic [15:0] c;
    frm = '{adr, fc, rg[15:8], rg[7:0], dat[15:8], dat[7:0], 8'h00, 8'h00};
    c = crc16(frm, 6) ^ flip;
    frm[6] = c[7:0];
    frm[7] = c[15:8];
    @(negedge clk);
    for (int k = 0; k < 8; k++) begin
      send_byte(frm[k]);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // wait bound covers a whole request still being sent
  task automatic get_reply(input int n, output logic [7:0] q [8], output bit ok);
    int t;
    ok = 1'b1;
    q = '{default: 8'h00};
    for (int k = 0; k < n; k++) begin
      t = 0;
      while (txd !== 1'b0 && t < 100 * DIV) begin
        @(posedge clk);
        t++;
      end
      if (t >= 100 * DIV) ok = 1'b0;
      repeat (DIV / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge clk);
        q[k][i] = txd;
      end
      repeat (DIV) @(posedge clk);
      if (txd !== 1'b1) ok = 1'b0;
    end
  endtask
endmodule

// File: test/testbench.sv
// self-checking bench for the gripper modbus register bank
`timescale 1ns/10ps
module testbench import gmb_pkg::*;;
  logic clk_sys, resetn, rxd, txd, tx_en;
  gmb_status_t status;
  logic [15:0] curr, cfg_word;
  // store contents before the first power-up
  logic [15:0] nv_close = 16'h0033;
  logic [15:0] nv_open = 16'h0101;
  // shortened bit time keeps the run short, the inter-frame gap is set on its own to 20000 cycles
  localparam int SIM_DIV = 16;
  logic [7:0] temp_a, temp_b;
  gmb_nv_wr_t nv_wr;
  logic [14:0] close_mm, open_mm;
  int n_fail = 0;
  int cmp_count = 0;
  int n_nv = 0;
  logic [7:0] q [8];
  bit ok;
  ////////////////////////////////////////////////////////////
  gmb_regbank #(.GAP(20000), .DIV(SIM_DIV)) dut_u (.CLK_SYS(clk_sys), .RESETN(resetn), .RXD(rxd),
    .TXD(txd), .TX_EN(tx_en), .STATUS(status), .CURRENT_TENTHS(curr), .TEMP_A(temp_a),
    .TEMP_B(temp_b), .NV_CLOSE_IN(nv_close), .NV_OPEN_IN(nv_open), .NV_WR(nv_wr),
    .CFG_WORD(cfg_word), .CLOSE_MM(close_mm), .OPEN_MM(open_mm));
  gmb_client_model #(.DIV(SIM_DIV)) client_u (.clk(clk_sys), .txd(txd), .rxd(rxd));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // non-volatile store stand-in, survives the bench's resets
  always @(negedge clk_sys) begin
    if (nv_wr.we === 1'b1) begin
      n_nv <= n_nv + 1;
      if (nv_wr.sel) nv_open <= nv_wr.data;
      else nv_close <= nv_wr.data;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic do_reset;
    @(negedge clk_sys);
    resetn = 1'b0;
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  // fork: the reply may start before the last stop bit has ended
  task automatic xfer(input logic [7:0] adr, input logic [7:0] fc, input logic [15:0] rg,
      input logic [15:0] dat, input logic [15:0] flip, input int n);
    // half duplex: no request while the driver still holds the line
    for (int t = 0; t < 20 * SIM_DIV && tx_en !== 1'b0; t++) begin
      @(negedge clk_sys);
    end
    chk({15'h0, tx_en}, 16'h0000, "driver released");
    fork
      client_u.send_req(adr, fc, rg, dat, flip);
      client_u.get_reply(n, q, ok);
    join
    @(negedge clk_sys);
  endtask
  task automatic t_read(input logic [15:0] rg, input logic [15:0] exp);
    logic [15:0] c;
    xfer(SRV_ADDR, FC_READ_IN, rg, RD_QTY, 16'h0000, 7);
    c = client_u.crc16(q, 5);
    chk({15'h0, tx_en}, 16'h0001, "driver held to last stop");
    chk({15'h0, ok}, 16'h0001, "read framing");
    chk({q[0], q[1]}, {SRV_ADDR, FC_READ_IN}, "read header");
    chk({8'h00, q[2]}, 16'h0002, "byte count");
    chk({q[3], q[4]}, exp, "read data");
    chk({q[6], q[5]}, c, "read crc");
  endtask
  task automatic t_write(input logic [15:0] rg, input logic [15:0] dat);
    xfer(SRV_ADDR, FC_WRITE_ONE, rg, dat, 16'h0000, 8);
    chk({15'h0, ok}, 16'h0001, "write framing");
    for (int k = 0; k < 8; k += 2) begin
      chk({q[k], q[k+1]}, {client_u.frm[k], client_u.frm[k+1]}, "echo");
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_power;
    chk(cfg_word, 16'h0007, "cfg reset");
    chk({1'b0, close_mm}, 16'h0019, "close from store");
    chk({1'b0, open_mm}, 16'h0080, "open from store");
  endtask
  task automatic t_reads;
    status = '{fault_code: 8'h3C, motion_flag: 1'b1, grip_in_flag: 1'b0, obj_state: 2'h2,
      op_mode: 2'h1, goto_request_flag: 1'b0, enabled_flag: 1'b1};
    t_read(REG_STATE, 16'h3CA5);
    curr = 16'h0008;
    t_read(REG_CURR, 16'h0008);
    chk({q[5], q[6]}, 16'hCD3A, "current crc");
    temp_a = 8'h29;
    temp_b = 8'h2A;
    t_read(REG_TEMP, 16'h292A);
    chk({q[5], q[6]}, 16'h52B3, "temp crc");
  endtask
  task automatic t_presets;
    int n0;
    n0 = n_nv;
    t_write(REG_CFG, 16'h0003);
    chk(cfg_word, 16'h0003, "serial mode");
    chk(16'(n_nv - n0), 16'h0000, "cfg not stored");
    t_write(REG_CLOSE, 16'h0014);
    chk(nv_close, 16'h0014, "close stored");
    chk({1'b0, close_mm}, 16'd10, "close mm");
    t_write(REG_OPEN, 16'h00FA);
    chk(nv_open, 16'h00FA, "open stored");
    chk({1'b0, open_mm}, 16'd125, "open mm");
    chk(16'(n_nv - n0), 16'h0002, "store writes");
    t_write(REG_CFG, 16'h0007);
    chk(cfg_word, 16'h0007, "discrete mode");
    chk({1'b0, close_mm}, 16'd10, "close kept");
  endtask
  task automatic t_refuse;
    int n0;
    n0 = n_nv;
    xfer(SRV_ADDR, FC_WRITE_ONE, REG_CLOSE, 16'h0002, 16'h0001, 1);
    chk({15'h0, ok}, 16'h0000, "bad crc answered");
    xfer(8'h57, FC_WRITE_ONE, REG_CLOSE, 16'h0002, 16'h0000, 1);
    chk({15'h0, ok}, 16'h0000, "other address answered");
    xfer(SRV_ADDR, FC_READ_IN, REG_CLOSE, RD_QTY, 16'h0000, 1);
    chk({15'h0, ok}, 16'h0000, "write-only read answered");
    chk(16'(n_nv - n0), 16'h0000, "refused write stored");
    chk({1'b0, close_mm}, 16'd10, "refused write taken");
  endtask
  task automatic t_repower;
    do_reset;
    chk({1'b0, close_mm}, 16'd10, "close reloaded");
    chk({1'b0, open_mm}, 16'd125, "open reloaded");
    chk(cfg_word, 16'h0007, "cfg after repower");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    status = '0;
    curr = 16'h0000;
    temp_a = 8'h00;
    temp_b = 8'h00;
    do_reset;
    t_power;
    t_reads;
    t_presets;
    t_refuse;
    t_repower;
    stop_test;
  end
  initial begin
    // about ten exchanges of some 2600 cycles each, with wide margin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    $display("Error %0t: watchdog expired", $time);
    stop_test;
  end
endmodule
